/* File: lcd_pkg.sv */
// Shared constants, register layout and types for the segment display controller.
package lcd_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FCR    = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam logic [7:0] OFS_CLR    = 8'h0C;
  localparam logic [7:0] OFS_PIX_LO = 8'h14;
  localparam logic [7:0] OFS_PIX_HI = 8'h50;
  localparam int         PIX_WORDS  = 16;
  localparam int         NUM_COM    = 8;
  localparam int         NUM_SEG    = 44;
  // Frame control field layout; bit 2 is reserved and reads zero.
  localparam int           FCR_W    = 26;
  localparam logic [25:0]  FCR_MASK = 26'h3FF_FFFB;
  localparam int           FCR_UPDATE_DONE_IRQ_ENABLE_BIT = 3;
  localparam int           FCR_FRAME_START_IRQ_ENABLE_BIT = 1;
  // Status bit positions and reset value.
  localparam int          ST_SYNC_BIT = 5;
  localparam int          ST_RDY_BIT  = 4;
  localparam int          ST_UDD_BIT  = 3;
  localparam int          ST_UDR_BIT  = 2;
  localparam int          ST_SOF_BIT  = 1;
  localparam int          ST_ENS_BIT  = 0;
  localparam logic [31:0] STAT_RESET  = 32'h0000_0020;
  // Flag clear bit positions.
  localparam int CLR_UDD_BIT = 3;
  localparam int CLR_SOF_BIT = 1;
  // Upper segment word widths: commons 0..3 carry 12 bits, commons 4..7 carry 8.
  localparam logic [11:0] HI_MASK_WIDE   = 12'hFFF;
  localparam logic [11:0] HI_MASK_NARROW = 12'h0FF;
  localparam int          WIDE_COMS      = 4;
  // Timing bases.
  localparam int          DIV_BASE   = 16;
  localparam logic [9:0]  BLINK_HALF = 10'h004;
  // Bus responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Display control fields, packed so that bit 0 is the enable.
  typedef struct packed {
    logic       remap;
    logic [1:0] bias;
    logic [2:0] duty;
    logic       voltage_source_select;
    logic       en;
  } ctrl_t;

  // Frame control fields; rest holds contrast, dead time, pulse, irq enables and drive.
  typedef struct packed {
    logic [3:0] ps;
    logic [3:0] div;
    logic [1:0] blink;
    logic [2:0] flash_rate;
    logic [12:0] rest;
  } fcr_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } disp_state_t;
endpackage : lcd_pkg

/* File: segment_lcd_controller_regs.sv */
// Segment display controller: register file, frame timing, buffers and pin drive.
//
// The AXI4-Lite register port is this design's own decision.
module segment_lcd_controller_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              panel_clock,
  input  wire logic              bus_clock_stopped,
  input  wire logic              converter_good,
  output logic [7:0]             com_out,
  output logic [43:0]            seg_out,
  output logic [1:0]             bias_sel,
  output logic [2:0]             duty_sel,
  output logic                   ext_supply_sel,
  output logic                   converter_enable,
  output logic                   update_done_irq,
  output logic                   frame_start_irq
);
  // Register group state.
  lcd_pkg::ctrl_t       ctrl_r,    ctrl_nxt;
  lcd_pkg::fcr_t        fcr_r,     fcr_nxt;
  lcd_pkg::fcr_t        fcr_act_r, fcr_act_nxt;
  lcd_pkg::disp_state_t state_r,   state_nxt;
  logic                 fcr_pend_r, fcr_pend_nxt;
  logic                 synced_r,   synced_nxt;
  logic                 udd_r,      udd_nxt;
  logic                 udr_r,      udr_nxt;
  logic                 sof_r,      sof_nxt;
  logic [31:0]          pix_r   [lcd_pkg::PIX_WORDS];
  logic [31:0]          pix_nxt [lcd_pkg::PIX_WORDS];
  logic [43:0]          buf_r   [lcd_pkg::NUM_COM];
  logic [43:0]          buf_nxt [lcd_pkg::NUM_COM];
  // Bus slave state.
  logic                 aw_held_r, aw_held_nxt;
  logic                 w_held_r,  w_held_nxt;
  logic [ADDR_W-1:0]    waddr_r,   waddr_nxt;
  logic [31:0]          wdata_r,   wdata_nxt;
  logic [3:0]           wstrb_r,   wstrb_nxt;
  logic                 bvalid_r,  bvalid_nxt;
  logic [1:0]           bresp_r,   bresp_nxt;
  logic                 rvalid_r,  rvalid_nxt;
  logic [1:0]           rresp_r,   rresp_nxt;
  logic [31:0]          rdata_r,   rdata_nxt;
  // Timing group state.
  logic                 pclk_d_r;
  logic [14:0]          ps_cnt_r,    ps_cnt_nxt;
  logic [4:0]           div_cnt_r,   div_cnt_nxt;
  logic [2:0]           com_idx_r,   com_idx_nxt;
  logic [9:0]           blink_cnt_r, blink_cnt_nxt;
  logic                 blink_ph_r,  blink_ph_nxt;
  logic [7:0]           com_out_r,   com_out_nxt;
  logic [43:0]          seg_out_r,   seg_out_nxt;
  // Combinational helpers.
  logic                 pclk_tick, ps_tick, div_tick, frame_start, enabled_status, do_copy, do_wr;
  logic [3:0]           ncom;
  logic [31:0]          wmask, status_word;
  logic [43:0]          row;

  // Number of active commons for each duty code.
  function automatic logic [3:0] com_count(input logic [2:0] duty);
    case (duty)
      3'h0:    com_count = 4'h1;
      3'h1:    com_count = 4'h2;
      3'h2:    com_count = 4'h3;
      3'h3:    com_count = 4'h4;
      default: com_count = 4'h8;
    endcase
  endfunction : com_count

  // Storable bits of a pixel word: upper words hold only existing segments.
  function automatic logic [31:0] pix_mask(input int idx);
    if (idx % 2 == 0) begin
      pix_mask = 32'hFFFF_FFFF;
    end else if (idx / 2 < lcd_pkg::WIDE_COMS) begin
      pix_mask = {20'h0_0000, lcd_pkg::HI_MASK_WIDE};
    end else begin
      pix_mask = {20'h0_0000, lcd_pkg::HI_MASK_NARROW};
    end
  endfunction : pix_mask

  // Handshakes are combinational; each channel takes one item and holds it.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign do_wr         = aw_held_r && w_held_r && !bvalid_r;
  assign wmask         = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // Enabled status covers the whole time from enable until the last frame ends.
  assign enabled_status          = (state_r != lcd_pkg::ST_OFF);
  assign ncom         = com_count(ctrl_r.duty);
  assign pclk_tick    = panel_clock && !pclk_d_r;
  assign ps_tick      = pclk_tick && (ps_cnt_r == 15'((15'h1 << fcr_act_r.ps) - 15'h1));
  assign div_tick     = ps_tick
                        && (div_cnt_r == 5'(lcd_pkg::DIV_BASE + int'(fcr_act_r.div) - 1));
  assign frame_start  = enabled_status && div_tick
                        && (state_r == lcd_pkg::ST_START || {1'b0, com_idx_r} == ncom - 4'h1);
  // A pending copy lands only at a frame start and only while software keeps enable set.
  assign do_copy      = frame_start && udr_r && ctrl_r.en;
  assign status_word  = {26'h000_0000, synced_r, converter_good && converter_enable,
                         udd_r, udr_r, sof_r, enabled_status};

  // Register group next state: bus slave, control registers, flags and buffers.
  always_comb begin
    ctrl_nxt    = ctrl_r;
    fcr_nxt     = fcr_r;
    fcr_act_nxt = fcr_act_r;
    state_nxt   = state_r;
    fcr_pend_nxt = fcr_pend_r;
    synced_nxt  = synced_r;
    udd_nxt     = udd_r;
    udr_nxt     = udr_r;
    sof_nxt     = sof_r;
    pix_nxt     = pix_r;
    buf_nxt     = buf_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !s_axi_rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    // The panel-side copy of frame control refreshes on a panel clock edge.
    if (pclk_tick && fcr_pend_r) begin
      fcr_act_nxt  = fcr_r;
      fcr_pend_nxt = 1'b0;
      synced_nxt   = 1'b1;
    end
    // Hardware events first; clears below are ordered to give each flag its priority.
    if (frame_start) begin
      sof_nxt = 1'b1;
      if (state_r == lcd_pkg::ST_START) begin
        state_nxt = ctrl_r.en ? lcd_pkg::ST_RUN : lcd_pkg::ST_OFF;
      end else if (!ctrl_r.en) begin
        state_nxt = lcd_pkg::ST_OFF;
      end
    end
    for (int c = 0; c < lcd_pkg::NUM_COM; c++) begin
      if (do_copy && (state_r != lcd_pkg::ST_RUN || c < int'(ncom))) begin
        buf_nxt[c] = {pix_r[2*c+1][11:0], pix_r[2*c]};
      end
    end
    if (do_copy) begin
      udr_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = lcd_pkg::RESP_OKAY;
      if (waddr_r == lcd_pkg::OFS_CTRL) begin
        ctrl_nxt = lcd_pkg::ctrl_t'((ctrl_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]));
        if (enabled_status) begin
          ctrl_nxt = lcd_pkg::ctrl_t'({ctrl_r[7:1], ctrl_nxt.en});
        end
        // Looking at the next state lets a re-enable restart a display that stops this cycle.
        if (ctrl_nxt.en && state_nxt == lcd_pkg::ST_OFF) begin
          state_nxt = lcd_pkg::ST_START;
        end
      end else if (waddr_r == lcd_pkg::OFS_FCR) begin
        fcr_nxt = lcd_pkg::fcr_t'(((fcr_r & ~wmask[25:0]) | (wdata_r[25:0] & wmask[25:0]))
                                  & lcd_pkg::FCR_MASK);
        fcr_pend_nxt = 1'b1;
        synced_nxt   = 1'b0;
      end else if (waddr_r == lcd_pkg::OFS_STAT) begin
        // A repeated request while one is pending must not re-arm a copy that just finished.
        if (wstrb_r[0] && wdata_r[lcd_pkg::ST_UDR_BIT] && !udr_r) begin
          udr_nxt = 1'b1;
        end
      end else if (waddr_r == lcd_pkg::OFS_CLR) begin
        if (wstrb_r[0] && wdata_r[lcd_pkg::CLR_UDD_BIT]) begin
          udd_nxt = 1'b0;
        end
        if (wstrb_r[0] && wdata_r[lcd_pkg::CLR_SOF_BIT]) begin
          sof_nxt = 1'b0;
        end
      end else if (waddr_r >= lcd_pkg::OFS_PIX_LO && waddr_r <= lcd_pkg::OFS_PIX_HI
                   && waddr_r[1:0] == 2'h0) begin
        // Pixel words are frozen while a copy is pending so the buffer sees one image.
        for (int i = 0; i < lcd_pkg::PIX_WORDS; i++) begin
          if (!udr_r && waddr_r == ADDR_W'(lcd_pkg::OFS_PIX_LO + 8'(4 * i))) begin
            pix_nxt[i] = ((pix_r[i] & ~wmask) | (wdata_r & wmask)) & pix_mask(i);
          end
        end
      end else begin
        bresp_nxt = lcd_pkg::RESP_SLVERR;
      end
    end
    // Update done set is applied last so it wins over a clear in the same cycle.
    if (do_copy) begin
      udd_nxt = 1'b1;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = lcd_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr == lcd_pkg::OFS_CTRL) begin
        rdata_nxt = {24'h00_0000, ctrl_r};
      end else if (s_axi_araddr == lcd_pkg::OFS_FCR) begin
        rdata_nxt = {6'h00, fcr_r};
      end else if (s_axi_araddr == lcd_pkg::OFS_STAT) begin
        rdata_nxt = status_word;
      end else if (s_axi_araddr == lcd_pkg::OFS_CLR) begin
        rdata_nxt = 32'h0000_0000;
      end else if (s_axi_araddr >= lcd_pkg::OFS_PIX_LO && s_axi_araddr <= lcd_pkg::OFS_PIX_HI
                   && s_axi_araddr[1:0] == 2'h0) begin
        for (int i = 0; i < lcd_pkg::PIX_WORDS; i++) begin
          if (s_axi_araddr == ADDR_W'(lcd_pkg::OFS_PIX_LO + 8'(4 * i))) begin
            rdata_nxt = pix_r[i];
          end
        end
      end else begin
        rresp_nxt = lcd_pkg::RESP_SLVERR;
      end
    end
  end

  // Register group flip-flops; synced flag resets to 1 as the status reset value says.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= '0;
      fcr_r      <= '0;
      fcr_act_r  <= '0;
      state_r    <= lcd_pkg::ST_OFF;
      fcr_pend_r <= 1'b0;
      synced_r   <= lcd_pkg::STAT_RESET[lcd_pkg::ST_SYNC_BIT];
      udd_r      <= 1'b0;
      udr_r      <= 1'b0;
      sof_r      <= 1'b0;
      pix_r      <= '{default: '0};
      buf_r      <= '{default: '0};
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      waddr_r    <= '0;
      wdata_r    <= '0;
      wstrb_r    <= '0;
      bvalid_r   <= 1'b0;
      bresp_r    <= lcd_pkg::RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= lcd_pkg::RESP_OKAY;
      rdata_r    <= '0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      fcr_r      <= fcr_nxt;
      fcr_act_r  <= fcr_act_nxt;
      state_r    <= state_nxt;
      fcr_pend_r <= fcr_pend_nxt;
      synced_r   <= synced_nxt;
      udd_r      <= udd_nxt;
      udr_r      <= udr_nxt;
      sof_r      <= sof_nxt;
      pix_r      <= pix_nxt;
      buf_r      <= buf_nxt;
      aw_held_r  <= aw_held_nxt;
      w_held_r   <= w_held_nxt;
      waddr_r    <= waddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Timing group next state: dividers, common scan, blink phase and pin images.
  always_comb begin
    ps_cnt_nxt    = ps_cnt_r;
    div_cnt_nxt   = div_cnt_r;
    com_idx_nxt   = com_idx_r;
    blink_cnt_nxt = blink_cnt_r;
    blink_ph_nxt  = blink_ph_r;
    row           = buf_r[com_idx_r];
    if (!enabled_status) begin
      ps_cnt_nxt    = '0;
      div_cnt_nxt   = '0;
      com_idx_nxt   = '0;
      blink_cnt_nxt = '0;
      blink_ph_nxt  = 1'b0;
    end else if (pclk_tick) begin
      ps_cnt_nxt = ps_tick ? 15'h0000 : ps_cnt_r + 15'h0001;
      if (ps_tick) begin
        div_cnt_nxt = div_tick ? 5'h00 : div_cnt_r + 5'h01;
      end
      if (div_tick) begin
        com_idx_nxt = frame_start ? 3'h0 : com_idx_r + 3'h1;
      end
      // Blink phase flips every half period so one on plus one off is 8 << rate frames.
      if (frame_start) begin
        if (blink_cnt_r == 10'((lcd_pkg::BLINK_HALF << fcr_act_r.flash_rate) - 10'h001)) begin
          blink_cnt_nxt = '0;
          blink_ph_nxt  = !blink_ph_r;
        end else begin
          blink_cnt_nxt = blink_cnt_r + 10'h001;
        end
      end
    end
    if (blink_ph_r) begin
      case (fcr_act_r.blink)
        2'h1:    row[0] = (com_idx_r == 3'h0) ? 1'b0 : row[0];
        2'h2:    row[0] = 1'b0;
        2'h3:    row    = '0;
        default: row    = row;
      endcase
    end
    if (ctrl_r.remap) begin
      row[31:28] = row[43:40];
    end
    com_out_nxt = enabled_status ? (8'h01 << com_idx_r) : 8'h00;
    seg_out_nxt = enabled_status ? row : 44'h000_0000_0000;
  end

  // Timing group flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_d_r    <= 1'b0;
      ps_cnt_r    <= '0;
      div_cnt_r   <= '0;
      com_idx_r   <= '0;
      blink_cnt_r <= '0;
      blink_ph_r  <= 1'b0;
      com_out_r   <= '0;
      seg_out_r   <= '0;
    end else begin
      pclk_d_r    <= panel_clock;
      ps_cnt_r    <= ps_cnt_nxt;
      div_cnt_r   <= div_cnt_nxt;
      com_idx_r   <= com_idx_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_ph_r  <= blink_ph_nxt;
      com_out_r   <= com_out_nxt;
      seg_out_r   <= seg_out_nxt;
    end
  end

  // Analog selects follow the live control register, converter enable also needs enabled status; interrupts are gated levels.
  assign com_out          = com_out_r;
  assign seg_out          = seg_out_r;
  assign bias_sel         = ctrl_r.bias;
  assign duty_sel         = ctrl_r.duty;
  assign ext_supply_sel   = ctrl_r.voltage_source_select;
  assign converter_enable = enabled_status && !ctrl_r.voltage_source_select;
  assign update_done_irq  = udd_r && fcr_r.rest[lcd_pkg::FCR_UPDATE_DONE_IRQ_ENABLE_BIT] && enabled_status
                            && !bus_clock_stopped;
  assign frame_start_irq  = sof_r && fcr_r.rest[lcd_pkg::FCR_FRAME_START_IRQ_ENABLE_BIT];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_remap_pins:  assert property (ctrl_r.remap && enabled_status |=> seg_out[31:28] == seg_out[43:40])
    else $error("remap pins wrong");
  a_dis_ground:  assert property (!enabled_status |=> com_out == 8'h00 && seg_out == 44'h000_0000_0000)
    else $error("pins not grounded while disabled");
  a_ctrl_protect: assert property (enabled_status |=> ctrl_r[7:1] == $past(ctrl_r[7:1]))
    else $error("protected field changed while enabled");
  a_ens_rise:    assert property ($rose(ctrl_r.en) |-> enabled_status)
    else $error("enabled status late");
  a_ens_hold:    assert property (enabled_status && !frame_start |=> enabled_status)
    else $error("enabled status fell mid frame");
  a_udd_wins:    assert property (do_copy |=> udd_r)
    else $error("update done lost");
  a_sof_clear:   assert property (do_wr && waddr_r == lcd_pkg::OFS_CLR && wstrb_r[0]
                                  && wdata_r[lcd_pkg::CLR_SOF_BIT] |=> !sof_r)
    else $error("frame start clear lost");
  a_udr_hold:    assert property (udr_r && !do_copy |=> udr_r)
    else $error("update request dropped early");
  a_pix_block:   assert property (udr_r |=> pix_r[0] == $past(pix_r[0]))
    else $error("pixel write while update pending");
  a_irq_gate:    assert property (!enabled_status || bus_clock_stopped |-> !update_done_irq)
    else $error("update irq while gated");
  a_sync_clear:  assert property (do_wr && waddr_r == lcd_pkg::OFS_FCR |=> !synced_r)
    else $error("sync flag not cleared");

  c_frame:   cover property (frame_start ##[1:1000] frame_start);
  c_copy:    cover property (do_copy && state_r == lcd_pkg::ST_RUN);
  c_stop:    cover property (enabled_status ##1 !enabled_status);
  c_blink:   cover property ($rose(blink_ph_r));
endmodule : segment_lcd_controller_regs

/* File: panel_model.sv */
// Far side of the display: panel clock source and converter feedback; the pin inputs go unused.
module panel_model (
  input  wire logic        aclk,
  input  wire logic [7:0]  com_out,
  input  wire logic [43:0] seg_out,
  output logic             panel_clock,
  output logic             converter_good
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r = 2'h0;
  // Panel clock at a quarter of the bus rate keeps every tick visible on aclk.
  always @(posedge aclk) begin
    div_r <= div_r + 2'h1;
  end
  assign panel_clock = div_r[1];
  // The converter reports a good supply at all times.
  assign converter_good = 1'b1;
endmodule : panel_model

/* File: segment_lcd_controller_regs_tb.sv */
// Self-checking bench for the segment display controller.
module segment_lcd_controller_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, stop = 0;
  logic awr, wr_r, bv, arr, rv, pclk, good, udi, sfi, cen, ext;
  logic [7:0]  awa = 8'h00, ara = 8'h00, com;
  logic [31:0] wd = 32'h0000_0000, rd_d;
  logic [1:0]  bresp, rresp, bias, resp;
  logic [2:0]  duty;
  logic [43:0] seg;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  segment_lcd_controller_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .panel_clock(pclk), .bus_clock_stopped(stop), .converter_good(good), .com_out(com),
    .seg_out(seg), .bias_sel(bias), .duty_sel(duty), .ext_supply_sel(ext),
    .converter_enable(cen), .update_done_irq(udi), .frame_start_irq(sfi));
  panel_model i_panel (.aclk(aclk), .com_out(com), .seg_out(seg), .panel_clock(pclk),
    .converter_good(good));
  // Ends the run with the verdict.
  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // A hang counts as a mismatch.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin n_mismatch++; print_verdict(); end
  end
  task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    compares++;
    if (g !== e) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end
  endtask : chk
  // Write: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk); awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
    end while (!bv);
    resp = bresp; br <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk); ara <= a; arv <= 1; rr <= 1;
    do begin @(posedge aclk); if (arv && arr) arv <= 0; end while (!rv);
    d = rd_d; resp = rresp; rr <= 0;
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rchk
  task automatic wait_stat(input int i, input logic v);
    logic [31:0] d;
    do rd(8'h08, d); while (d[i] !== v);
  endtask : wait_stat
  // Reset values and an unmapped read.
  task automatic t_reset;
    rchk("status", 8'h08, 32'h0000_0020);
    rchk("ctrl", 8'h00, 32'h0000_0000);
    rchk("pixel", 8'h50, 32'h0000_0000);
    rchk("hole", 8'h10, 32'h0000_0000);
    chk("hole resp", lcd_pkg::RESP_SLVERR, resp);
  endtask : t_reset
  // Control fields reach the analog selects while disabled.
  task automatic t_ctrl;
    wr(8'h00, 32'h0000_00B2);
    rchk("ctrl", 8'h00, 32'h0000_00B2);
    chk("bias", 2'h1, bias);
    chk("duty", 3'h4, duty);
    chk("ext", 1'b1, ext);
    chk("cen off", 1'b0, cen);
    wr(8'h00, 32'h0000_0080);
  endtask : t_ctrl
  // Flash mode 11 blanks every segment in the off phase, which comes within a few frames.
  task automatic t_blink;
    wr(8'h04, 32'h0003_000A);
    repeat (600) begin
      @(posedge aclk);
      if (seg === 44'h000_0000_0000) break;
    end
    chk("blink off", 44'h000_0000_0000, seg);
    wr(8'h04, 32'h0000_000A);
  endtask : t_blink
  // Update request, write protection, remap, irq gating, disable.
  task automatic t_update;
    wr(8'h04, 32'h0000_000A);
    wr(8'h14, 32'h1000_0001);
    wr(8'h18, 32'h0000_0F00);
    wr(8'h08, 32'h0000_0004);
    rchk("req", 8'h08, 32'h0000_0024);
    wr(8'h14, 32'h0000_0000);
    chk("wr resp", lcd_pkg::RESP_OKAY, resp);
    wr(8'h00, 32'h0000_0081);
    wait_stat(lcd_pkg::ST_UDD_BIT, 1'b1);
    rchk("stat", 8'h08, 32'h0000_003B);
    rchk("pix kept", 8'h14, 32'h1000_0001);
    chk("udi", 1'b1, udi);
    chk("sfi", 1'b1, sfi);
    chk("cen", 1'b1, cen);
    stop <= 1;
    repeat (2) @(posedge aclk);
    chk("udi stop", 1'b0, udi);
    stop <= 0;
    repeat (70) @(posedge aclk);
    chk("com", 8'h01, com);
    chk("remap", 5'h1F, {seg[31:28], seg[0]});
    t_blink();
    wr(8'h00, 32'h0000_0001);
    rchk("ctrl prot", 8'h00, 32'h0000_0081);
    wr(8'h0C, 32'h0000_0008);
    wait_stat(lcd_pkg::ST_UDD_BIT, 1'b0);
    wr(8'h00, 32'h0000_0080);
    wait_stat(lcd_pkg::ST_ENS_BIT, 1'b0);
    chk("com off", 8'h00, com);
    chk("seg off", 44'h000_0000_0000, seg);
  endtask : t_update
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_ctrl();
    t_update();
    print_verdict();
  end
endmodule : segment_lcd_controller_regs_tb
